// >>> hdl/tmc_timer.sv
`timescale 1ns/10ps
`include "tmc_defines.svh"

module tmc_timer #(
  parameter int PRESCALE_BITS = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_other_rst,
  input wire tmc_pkg::tmc_bus_s i_bus,
  input wire logic i_ext_clock_pin,
  input wire logic i_osc_input_pin,
  input wire logic i_sleep,
  input wire logic [3:0] i_compare_unit_mode_field,
  input wire logic i_compare_event,
  output logic [7:0] o_rdata,
  output logic [15:0] o_count,
  output logic o_timebase_ok,
  output logic o_osc_enable,
  output logic o_irq,
  output logic o_wake
);

  // ****************************************************************
  // State.
  // ****************************************************************
  tmc_pkg::tmc_ctrl_s ctrl;
  tmc_pkg::tmc_mode_e mode;
  logic [15:0] count;
  logic [1:0] count_loaded;
  logic [7:0] global_irq;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] phase;
  logic [PRESCALE_BITS-1:0] pre_cnt;
  logic src_prev;
  logic pre_prev;
  logic sync_samp;
  logic sync_prev;

  logic src_level;
  logic src_rise;
  logic pre_out;
  logic pre_rise;
  logic sync_rise;
  logic inc;
  logic wr_low;
  logic wr_high;
  logic wr_count;
  logic trig_hit;
  logic ovf_now;
  logic [15:0] next_count;

  // ****************************************************************
  // Mode decode and clock source selection.
  // ****************************************************************

  // The bypass bit only matters once an external source is chosen.
  always_comb begin
    if (!ctrl.count_source_select) begin
      mode = tmc_pkg::TMC_TIMER;
    end else if (ctrl.sync_bypass) begin
      mode = tmc_pkg::TMC_ASYNC_COUNTER;
    end else begin
      mode = tmc_pkg::TMC_SYNC_COUNTER;
    end
  end

  // Timer mode uses the upper phase bit as the instruction clock level.
  always_comb begin
    if (mode == tmc_pkg::TMC_TIMER) begin
      src_level = phase[1];
    end else if (ctrl.low_freq_osc_enable) begin
      src_level = i_osc_input_pin;
    end else begin
      src_level = i_ext_clock_pin;
    end
  end

  assign src_rise = src_level & ~src_prev;

  // The divided output is a counter bit, so it stays symmetrical.
  always_comb begin
    unique case (ctrl.prescale_select)
      2'h0: pre_out = src_level;
      2'h1: pre_out = pre_cnt[0];
      2'h2: pre_out = pre_cnt[1];
      2'h3: pre_out = pre_cnt[2];
    endcase
  end

  assign pre_rise = pre_out & ~pre_prev;
  assign sync_rise = sync_samp & ~sync_prev;

  // ****************************************************************
  // Register port decode.
  // ****************************************************************
  assign wr_low = i_bus.wr && (i_bus.addr == `TMC_ADDR_COUNT_LOW);
  assign wr_high = i_bus.wr && (i_bus.addr == `TMC_ADDR_COUNT_HIGH);
  assign wr_count = wr_low | wr_high;

  // The trigger is dropped in asynchronous mode, where it cannot be
  // guaranteed anyway; ignoring it keeps the behaviour predictable.
  assign trig_hit = i_compare_event && (mode != tmc_pkg::TMC_ASYNC_COUNTER)
    && (i_compare_unit_mode_field == `TMC_CMP_SPECIAL_TRIG);

  // ****************************************************************
  // Increment selection per mode.
  // ****************************************************************

  // Sleep blocks the timer and synchronizer steps, but not
  // the asynchronous path.
  always_comb begin
    inc = 1'b0;
    if (ctrl.counter_run) begin
      unique case (mode)
        tmc_pkg::TMC_TIMER: inc = pre_rise && !i_sleep;
        tmc_pkg::TMC_SYNC_COUNTER: inc = sync_rise && !i_sleep;
        tmc_pkg::TMC_ASYNC_COUNTER: inc = pre_rise;
      endcase
    end
  end

  assign ovf_now = inc && (count == `TMC_COUNT_MAX) && !wr_count && !trig_hit;

  // A write wins over the trigger, and the trigger over a step.
  always_comb begin
    next_count = count;
    if (wr_low) begin
      next_count = {count[15:8], i_bus.wdata};
    end else if (wr_high) begin
      next_count = {i_bus.wdata, count[7:0]};
    end else if (trig_hit) begin
      next_count = `TMC_COUNT_ZERO;
    end else if (inc) begin
      next_count = count + 16'h0001;
    end
  end

  // ****************************************************************
  // Phase clocks and prescaler.
  // ****************************************************************

  // Phase runs from power-on reset; it is the instruction cycle.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Prescaler sees edges even in sleep; a count write clears it.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      pre_cnt <= '0;
      src_prev <= 1'b0;
      pre_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
      pre_prev <= pre_out;
      if (wr_count) begin
        pre_cnt <= '0;
      end else if (src_rise && ctrl.counter_run) begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

  // Synchronizer samples only on Q2 and Q4 and is off in sleep.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      sync_samp <= 1'b0;
      sync_prev <= 1'b0;
    end else if (!i_sleep) begin
      sync_prev <= sync_samp;
      if (phase == `TMC_PHASE_Q2 || phase == `TMC_PHASE_Q4) begin
        sync_samp <= pre_out;
      end
    end
  end

  // ****************************************************************
  // Count register.
  // ****************************************************************

  // No reset: the count survives every reset and is only cleared by
  // the trigger. count_loaded marks the bytes loaded since power-on.
  always_ff @(posedge i_mclk) begin
    count <= next_count;
    count_loaded <= i_rst ? 2'h0
      : (count_loaded | {wr_high | trig_hit, wr_low | trig_hit});
  end

  // ****************************************************************
  // Control and interrupt registers.
  // ****************************************************************

  // Only the power-on reset clears control; other resets keep it.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl <= `TMC_CTRL_RESET;
    end else if (i_bus.wr && i_bus.addr == `TMC_ADDR_CONTROL) begin
      ctrl <= i_bus.wdata[5:0];
    end
  end

  // Global interrupt control, cleared by every reset.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      global_irq <= `TMC_GLOBAL_IRQ_RESET;
    end else if (i_bus.wr && i_bus.addr == `TMC_ADDR_GLOBAL_IRQ) begin
      global_irq <= i_bus.wdata;
    end
  end

  // An overflow in the cycle of a software clear still sets the flag.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      overflow_flag <= 1'b0;
    end else if (ovf_now) begin
      overflow_flag <= 1'b1;
    end else if (i_bus.wr && i_bus.addr == `TMC_ADDR_PERIPH_FLAGS) begin
      overflow_flag <= i_bus.wdata[`TMC_OVF_BIT];
    end
  end

  // Overflow interrupt enable.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      overflow_irq_enable <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == `TMC_ADDR_PERIPH_ENABLES) begin
      overflow_irq_enable <= i_bus.wdata[`TMC_OVF_BIT];
    end
  end

  // ****************************************************************
  // Read port; data stands in the cycle after the strobe.
  // ****************************************************************

  // Reads sample the clock domain copy, so a byte is never torn.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_other_rst) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `TMC_ADDR_GLOBAL_IRQ: o_rdata <= global_irq;
        `TMC_ADDR_PERIPH_FLAGS: o_rdata <= {7'h00, overflow_flag};
        `TMC_ADDR_COUNT_LOW: o_rdata <= count[7:0];
        `TMC_ADDR_COUNT_HIGH: o_rdata <= count[15:8];
        `TMC_ADDR_CONTROL: o_rdata <= {2'h0, ctrl};
        `TMC_ADDR_PERIPH_ENABLES: o_rdata <= {7'h00, overflow_irq_enable};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Outputs, all registered.
  // ****************************************************************

  // Count copy for the compare unit; it loads next_count with the count, so it does not lag.
  always_ff @(posedge i_mclk) begin
    o_count <= next_count;
  end

  // Interrupt, wake, time base and oscillator controls.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_timebase_ok <= 1'b0;
      o_osc_enable <= 1'b0;
    end else begin
      o_irq <= overflow_flag && overflow_irq_enable
        && global_irq[`TMC_GIE_BIT] && global_irq[`TMC_PEIE_BIT];
      o_wake <= overflow_flag && overflow_irq_enable;
      o_timebase_ok <= (mode != tmc_pkg::TMC_ASYNC_COUNTER);
      o_osc_enable <= ctrl.low_freq_osc_enable;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  a_run_gate_hold: assert property (@(posedge i_mclk)
    disable iff (i_rst) &count_loaded && !ctrl.counter_run && !wr_count
    && !trig_hit |=> count == $past(count))
    else $error("Count moved while stopped.");

  a_overflow_sets_flag: assert property (@(posedge i_mclk)
    disable iff (i_rst || i_other_rst)
    ovf_now |=> overflow_flag && count == `TMC_COUNT_ZERO
    ##1 o_wake == $past(overflow_irq_enable))
    else $error("Wrap did not set the flag and wake.");

  a_trig_clears_only: assert property (@(posedge i_mclk)
    disable iff (i_rst || i_other_rst)
    trig_hit && !wr_count && !overflow_flag && !i_bus.wr
    |=> count == `TMC_COUNT_ZERO && !overflow_flag)
    else $error("Trigger clear wrong or set the flag.");

  a_write_beats_trig: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    wr_low && trig_hit |=> count[7:0] == $past(i_bus.wdata) )
    else $error("Trigger beat a software write.");

  a_write_clr_pre: assert property (@(posedge i_mclk)
    disable iff (i_rst || i_other_rst)
    wr_count |=> pre_cnt == '0)
    else $error("Count write left the prescaler set.");

  a_sleep_sync_hold: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    mode == tmc_pkg::TMC_SYNC_COUNTER && i_sleep && !wr_count
    && !trig_hit && &count_loaded |=> $stable(count))
    else $error("Synchronized count moved in sleep.");

  a_reset_ctrl_zero: assert property (@(posedge i_mclk)
    i_rst |=> ctrl == `TMC_CTRL_RESET && !o_osc_enable[*1])
    else $error("Control not cleared by power-on reset.");

  a_timer_phase: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    mode == tmc_pkg::TMC_TIMER && ctrl.prescale_select == 2'h0 && inc
    |-> phase == 2'h2)
    else $error("Timer step off the instruction edge.");

  a_async_no_base: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    mode == tmc_pkg::TMC_ASYNC_COUNTER ##1 mode == tmc_pkg::TMC_ASYNC_COUNTER
    |-> !o_timebase_ok)
    else $error("Asynchronous mode offered as time base.");

  a_sync_sample_q: assert property (@(posedge i_mclk)
    disable iff (i_rst || i_other_rst)
    !$stable(sync_samp) && !$past(i_rst || i_other_rst)
    |-> $past(phase) inside {`TMC_PHASE_Q2, `TMC_PHASE_Q4})
    else $error("Synchronizer sampled off Q2 and Q4.");

endmodule : tmc_timer

// >>> common/tmc_defines.svh
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define TMC_ADDR_GLOBAL_IRQ 8'h0B
`define TMC_ADDR_PERIPH_FLAGS 8'h0C
`define TMC_ADDR_COUNT_LOW 8'h0E
`define TMC_ADDR_COUNT_HIGH 8'h0F
`define TMC_ADDR_CONTROL 8'h10
`define TMC_ADDR_PERIPH_ENABLES 8'h8C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define TMC_OVF_BIT 0
`define TMC_GIE_BIT 7
`define TMC_PEIE_BIT 6
`define TMC_CTRL_RESET 6'h00
`define TMC_GLOBAL_IRQ_RESET 8'h00
`define TMC_COUNT_MAX 16'hFFFF
`define TMC_COUNT_ZERO 16'h0000

// ****************************************************************
// Compare unit mode code that selects the special event trigger.
// ****************************************************************
`define TMC_CMP_SPECIAL_TRIG 4'hB

// ****************************************************************
// Internal phase clocks: four oscillator cycles per instruction.
// ****************************************************************
`define TMC_PHASE_Q2 2'h1
`define TMC_PHASE_Q4 2'h3

`endif

// >>> common/tmc_pkg.sv
package tmc_pkg;

  // Control register fields, bit 5 down to bit 0.
  typedef struct packed {
    logic [1:0] prescale_select;
    logic low_freq_osc_enable;
    logic sync_bypass;
    logic count_source_select;
    logic counter_run;
  } tmc_ctrl_s;

  // One register port access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmc_bus_s;

  // Operating mode derived from the control register.
  typedef enum logic [1:0] {
    TMC_TIMER,
    TMC_SYNC_COUNTER,
    TMC_ASYNC_COUNTER
  } tmc_mode_e;

endpackage : tmc_pkg

// >>> test/tmc_ext_source.sv
`timescale 1ns/10ps

// ****************************************************************
// External clock source and watch crystal model.
// ****************************************************************
module tmc_ext_source (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_osc_sel,
  input wire logic [3:0] i_half,
  output logic o_ext_clock_pin,
  output logic o_osc_input_pin,
  output int o_edges
);
  logic level = 1'b0;
  logic [3:0] tick = 4'h0;
  int edges = 0;

  // Square wave of i_half cycles a phase; a high phase always completes and
  // the line parks low, so no stray edge is left between bursts.
  always @(posedge i_mclk) begin
    if (i_go || level) begin
      if (tick >= i_half - 4'h1) begin
        tick <= 4'h0;
        level <= ~level;
        if (!level) begin
          edges <= edges + 1;
        end
      end else begin
        tick <= tick + 4'h1;
      end
    end
  end

  // Only the selected source moves; the idle one stays parked low.
  assign o_ext_clock_pin = i_osc_sel ? 1'b0 : level;
  assign o_osc_input_pin = i_osc_sel ? level : 1'b0;
  assign o_edges = edges;
endmodule : tmc_ext_source

// >>> test/tmc_timer_test.sv
`timescale 1ns/10ps
`include "tmc_defines.svh"

module tmc_timer_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_other_rst = 1'b0;
  tmc_pkg::tmc_bus_s i_bus = '0;
  logic i_sleep = 1'b0;
  logic [3:0] mode = 4'h0;
  logic event_p = 1'b0;
  logic go = 1'b0;
  logic osc_sel = 1'b0;
  logic [3:0] half = 4'h4;
  logic ext_pin, osc_pin, irq, wake, tb_ok, osc_en;
  logic [7:0] rdata;
  logic [7:0] rd_val;
  logic [15:0] count;
  logic [15:0] base;
  int edges, e0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] cfg [4] = '{8'h03, 8'h0B, 8'h03, 8'h07};

  // ****************************************************************
  // Clock, design and far-side source.
  // ****************************************************************
  always #4 i_mclk = ~i_mclk;

  tmc_timer #(.PRESCALE_BITS(3)) u_tmc_timer (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_other_rst(i_other_rst), .i_bus(i_bus),
    .i_ext_clock_pin(ext_pin), .i_osc_input_pin(osc_pin),
    .i_sleep(i_sleep), .i_compare_unit_mode_field(mode),
    .i_compare_event(event_p), .o_rdata(rdata), .o_count(count),
    .o_timebase_ok(tb_ok), .o_osc_enable(osc_en), .o_irq(irq),
    .o_wake(wake));

  tmc_ext_source u_tmc_ext_source (.i_mclk(i_mclk), .i_go(go),
    .i_osc_sel(osc_sel), .i_half(half), .o_ext_clock_pin(ext_pin),
    .o_osc_input_pin(osc_pin), .o_edges(edges));

  // ****************************************************************
  // Bus cycles, waits and comparisons.
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_near(input logic [15:0] got, input int exp);
    tests_run++;
    if ($isunknown(got) || !(got >= exp - 1 && got <= exp + 1)) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_near

  task automatic waitn(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : waitn

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    i_bus <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    i_bus <= '0;
    #1;
    rd_val = rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check({8'h00, rd_val}, {8'h00, exp});
  endtask : rd_chk

  // Stop first so that no increment collides with the byte writes.
  task automatic set_count(input logic [15:0] v);
    wr(`TMC_ADDR_CONTROL, 8'h00);
    wr(`TMC_ADDR_COUNT_LOW, v[7:0]);
    wr(`TMC_ADDR_COUNT_HIGH, v[15:8]);
  endtask : set_count

  task automatic burst(input int n, input logic [3:0] h);
    @(posedge i_mclk);
    half <= h;
    go <= 1'b1;
    repeat (n * 2 * h - 1) @(posedge i_mclk);
    go <= 1'b0;
    waitn(2 * h + 16);
  endtask : burst

  task automatic pulse_event(input logic [3:0] m);
    @(posedge i_mclk);
    mode <= m;
    event_p <= 1'b1;
    @(posedge i_mclk);
    event_p <= 1'b0;
    waitn(2);
  endtask : pulse_event

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // A hang is cut short well beyond the fewer than two thousand cycles needed.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd_chk(`TMC_ADDR_CONTROL, 8'h00);
    rd_chk(`TMC_ADDR_PERIPH_FLAGS, 8'h00);
    rd_chk(`TMC_ADDR_PERIPH_ENABLES, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test reset values done");
    set_count(16'hFFFD);
    rd_chk(`TMC_ADDR_COUNT_LOW, 8'hFD);
    rd_chk(`TMC_ADDR_COUNT_HIGH, 8'hFF);
    wr(`TMC_ADDR_PERIPH_ENABLES, 8'h01);
    wr(`TMC_ADDR_GLOBAL_IRQ, 8'hC0);
    wr(`TMC_ADDR_CONTROL, 8'h01);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) waitn(1);
    check({15'h0, irq}, 16'h1);
    check_near(count, 1);
    check({15'h0, tb_ok}, 16'h1);
    rd_chk(`TMC_ADDR_PERIPH_FLAGS, 8'h01);
    wr(`TMC_ADDR_PERIPH_FLAGS, 8'h00);
    wr(`TMC_ADDR_CONTROL, 8'h00);
    waitn(2);
    check({15'h0, irq}, 16'h0);
    base = count;
    waitn(40);
    check(count, base);
    $display("test timer overflow done");
    for (int c = 0; c < 4; c++) begin
      set_count(16'h0000);
      wr(`TMC_ADDR_CONTROL, {2'b00, c[1:0], 4'h1});
      waitn(256);
      check_near(count, 64 >> c);
    end
    rd(`TMC_ADDR_COUNT_HIGH);
    base[15:8] = rd_val;
    rd(`TMC_ADDR_COUNT_LOW);
    rd(`TMC_ADDR_COUNT_HIGH);
    check({8'h00, rd_val}, {8'h00, base[15:8]});
    $display("test prescale done");
    for (int k = 0; k < 4; k++) begin
      set_count(16'h0100);
      osc_sel <= (k == 1);
      wr(`TMC_ADDR_CONTROL, cfg[k]);
      waitn(20);
      i_sleep <= (k >= 2);
      e0 = edges;
      burst(5, (k == 1) ? 4'h9 : 4'h4);
      i_sleep <= 1'b0;
      base = (k == 2) ? 16'h0 : 16'(edges - e0);
      check(count, 16'h0100 + base);
      check({15'h0, tb_ok}, {15'h0, k != 3});
      check({15'h0, osc_en}, {15'h0, k == 1});
    end
    set_count(16'hFFFE);
    wr(`TMC_ADDR_GLOBAL_IRQ, 8'h00);
    wr(`TMC_ADDR_CONTROL, 8'h07);
    i_sleep <= 1'b1;
    burst(3, 4'h4);
    i_sleep <= 1'b0;
    check(count, 16'h0001);
    check({14'h0, wake, irq}, 16'h2);
    $display("test counter modes done");
    wr(`TMC_ADDR_PERIPH_FLAGS, 8'h00);
    set_count(16'h1234);
    pulse_event(`TMC_CMP_SPECIAL_TRIG);
    check(count, 16'h0000);
    rd_chk(`TMC_ADDR_PERIPH_FLAGS, 8'h00);
    set_count(16'h1234);
    pulse_event(4'h8);
    check(count, 16'h1234);
    wr(`TMC_ADDR_CONTROL, 8'h06);
    pulse_event(`TMC_CMP_SPECIAL_TRIG);
    check(count, 16'h1234);
    wr(`TMC_ADDR_CONTROL, 8'h00);
    mode <= `TMC_CMP_SPECIAL_TRIG;
    @(posedge i_mclk);
    i_bus <= '{1'b1, 1'b0, `TMC_ADDR_COUNT_LOW, 8'h55};
    event_p <= 1'b1;
    @(posedge i_mclk);
    i_bus <= '0;
    event_p <= 1'b0;
    waitn(2);
    check(count, 16'h1255);
    $display("test trigger done");
    wr(`TMC_ADDR_CONTROL, 8'hFF);
    rd_chk(`TMC_ADDR_CONTROL, 8'h3F);
    set_count(16'hABCD);
    wr(`TMC_ADDR_CONTROL, 8'h30);
    @(posedge i_mclk);
    i_other_rst <= 1'b1;
    @(posedge i_mclk);
    i_other_rst <= 1'b0;
    rd_chk(`TMC_ADDR_CONTROL, 8'h30);
    rd_chk(`TMC_ADDR_COUNT_HIGH, 8'hAB);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    rd_chk(`TMC_ADDR_CONTROL, 8'h00);
    rd_chk(`TMC_ADDR_COUNT_LOW, 8'hCD);
    $display("test resets done");
    complete_run();
  end
endmodule : tmc_timer_test
